// ---- dv/otis_host_model.sv ----
`timescale 1ns/1ns
// upper controller: one-cycle motion commands
module otis_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench request
  input wire logic issue,
  input wire logic dirPos,
  input wire logic breakRule,
  input wire logic posOn,
  input wire logic negOn,
  // command out
  output logic cmdValid,
  output logic cmdDirPos
);
  logic blocked;
  assign blocked = dirPos ? posOn : negOn;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmdValid <= 1'b0;
      cmdDirPos <= 1'b0;
    end else begin
      cmdValid <= issue && (breakRule || !blocked);
      cmdDirPos <= dirPos;
    end
  end
endmodule

// ---- dv/otis_sequencer_sva.sv ----
`timescale 1ns/1ns
module otis_sequencer_sva import otis_pkg::*; #(
  parameter int CYCLE_DIV = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // inputs
  input wire logic posLimitPin,
  input wire logic negLimitPin,
  input wire otis_cfg_s cfgIn,
  input wire logic homingActive,
  input wire logic otherAlarm,
  input wire logic signed [SPEED_W-1:0] motorSpeed,
  input wire logic signed [TORQUE_W-1:0] torqueRequest,
  input wire logic [PCT_W-1:0] normalLimitPct,
  input wire logic cmdValid,
  input wire logic cmdDirPos,
  // outputs
  input wire otis_drive_s drive,
  input wire logic signed [TORQUE_W-1:0] torqueCmd,
  input wire logic runInhibitAlarm,
  input wire logic alarmStop,
  input wire logic cmdAccept,
  input wire logic cmdError,
  input wire logic [1:0] statusBits,
  input wire logic statusValid
);
  logic signed [TORQUE_W-1:0] estopLim;
  assign estopLim = TORQUE_W'(cfgIn.estopTorquePct);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence decelSeq;
    drive.dynamicBrake || drive.freeRun || drive.emergencyStop;
  endsequence
  sequence decelHeld;
    drive.forcePosCtrl && drive.haltPosCmd && drive.clearDeviation;
  endsequence
  cmd_answer_a: assert property (
    (cmdAccept || cmdError) |-> $past(cmdValid)) else $error("answer without command");
  cmd_excl_a: assert property (
    !(cmdAccept && cmdError)) else $error("accept and error together");
  alarm_prio_a: assert property (
    alarmStop && $past(alarmStop) |-> !(drive.dynamicBrake || drive.freeRun
      || drive.emergencyStop)) else $error("travel stop under alarm");
  inhibit_alarm_a: assert property (
    runInhibitAlarm && $past(runInhibitAlarm) |-> alarmStop) else $error("alarm stop missing");
  status_hide_a: assert property (
    !statusValid |-> statusBits == 2'h0) else $error("hidden status not zero");
  method_one_a: assert property (
    $onehot0({drive.dynamicBrake, drive.freeRun, drive.emergencyStop}))
    else $error("two stop methods at once");
  decel_hold_a: assert property (
    decelSeq |-> decelHeld) else $error("decel without position hold");
  block_torque_a: assert property (
    drive.blockPos && $past(drive.blockPos) |-> torqueCmd <= 0) else $error("torque into limit");
  estop_limit_a: assert property (
    drive.emergencyStop && $past(drive.emergencyStop) && $stable(estopLim) && estopLim != 0
      |-> torqueCmd <= estopLim && torqueCmd >= -estopLim) else $error("estop torque exceeded");
  discard_pulse_a: assert property (
    drive.discardDeviation |=> !drive.discardDeviation) else $error("discard held two cycles");
endmodule

bind otis_sequencer otis_sequencer_sva #(.CYCLE_DIV(CYCLE_DIV)) u_sva (
  .ref_clk(ref_clk), .rst(rst), .posLimitPin(posLimitPin), .negLimitPin(negLimitPin),
  .cfgIn(cfgIn), .homingActive(homingActive), .otherAlarm(otherAlarm),
  .motorSpeed(motorSpeed), .torqueRequest(torqueRequest), .normalLimitPct(normalLimitPct),
  .cmdValid(cmdValid), .cmdDirPos(cmdDirPos), .drive(drive), .torqueCmd(torqueCmd),
  .runInhibitAlarm(runInhibitAlarm), .alarmStop(alarmStop), .cmdAccept(cmdAccept),
  .cmdError(cmdError), .statusBits(statusBits), .statusValid(statusValid));

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb import otis_pkg::*;;
  logic ref_clk, rst, posPin, negPin, homing, othAlm, issue, dirPos, brk;
  logic cmdValid, cmdDirPos, acc, err, rAlm, aStop, sValid, a, e;
  logic [1:0] sBits;
  otis_cfg_s cfg;
  otis_drive_s drv;
  logic signed [SPEED_W-1:0] speed;
  logic signed [TORQUE_W-1:0] treq, tcmd;
  logic [PCT_W-1:0] nlim;
  int miscompares = 0;
  int n_compared = 0;

  otis_host_model u_host (.ref_clk(ref_clk), .rst(rst), .issue(issue), .dirPos(dirPos),
    .breakRule(brk), .posOn(posPin), .negOn(negPin), .cmdValid(cmdValid),
    .cmdDirPos(cmdDirPos));
  otis_sequencer #(.CYCLE_DIV(2)) u_dut (.ref_clk(ref_clk), .rst(rst), .posLimitPin(posPin),
    .negLimitPin(negPin), .cfgIn(cfg), .homingActive(homing), .otherAlarm(othAlm),
    .motorSpeed(speed), .torqueRequest(treq), .normalLimitPct(nlim), .cmdValid(cmdValid),
    .cmdDirPos(cmdDirPos), .drive(drv), .torqueCmd(tcmd), .runInhibitAlarm(rAlm),
    .alarmStop(aStop), .cmdAccept(acc), .cmdError(err), .statusBits(sBits),
    .statusValid(sValid));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task final_report;
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic doReset;
    rst <= 1'b1;
    settle(16);
    rst <= 1'b0;
    settle(1);
  endtask

  // answer may land up to four edges after the request
  task automatic sendCmd(input logic d);
    issue <= 1'b1;
    dirPos <= d;
    settle(1);
    issue <= 1'b0;
    a = 1'b0;
    e = 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      a |= acc;
      e |= err;
    end
    settle(1);
  endtask

  // counts discard pulses over ten edges, ends on an edge
  task automatic watchDiscard(output int n);
    n = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      n += drv.discardDeviation;
    end
    settle(1);
  endtask

  task automatic scStatus;
    logic [1:0] exp;
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 4; p++) begin
        cfg <= '{SETUP_DIRECTION, SEQ_DYN_BRAKE, 10'h000, {9'h000, m[1], 2'h0, m[0], 3'h0}};
        posPin <= p[1];
        negPin <= p[0];
        settle(10);
        exp = (m[0] ? {p[0], p[1]} : p[1:0]) ^ {2{m[1]}};
        cmp(sBits, exp, "status bits");
      end
    end
    cfg <= '{SETUP_DISABLED, SEQ_DYN_BRAKE, 10'h000, 16'h0004};
    settle(10);
    cmp({sValid, sBits}, 3'h0, "status hidden");
    cfg.expansion <= 16'h0000;
    settle(10);
    cmp({sValid, sBits}, 3'h7, "status shown");
  endtask

  task automatic scBlock;
    doReset();
    cfg <= '{SETUP_DIRECTION, SEQ_DYN_BRAKE, 10'h000, 16'h0000};
    posPin <= 1'b1;
    negPin <= 1'b0;
    treq <= 16'sd100;
    settle(10);
    cmp(tcmd, 16'h0000, "torque into limit");
    cmp({drv.blockPos, drv.blockNeg}, 2'h2, "block flags");
    treq <= -16'sd100;
    settle(10);
    cmp(tcmd, 16'(-100), "reverse torque");
    sendCmd(1'b1);
    cmp({a, e}, 2'h0, "withheld command");
    brk <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      cfg.expansion <= {6'h00, b[0], 9'h000};
      settle(10);
      sendCmd(1'b1);
      cmp({a, e}, {1'b0, b[0]}, "blocked command");
      sendCmd(1'b0);
      cmp({a, e}, 2'h2, "free direction");
    end
  endtask

  task automatic scIgnoreAlarm;
    doReset();
    cfg <= '{SETUP_DISABLED, SEQ_DYN_BRAKE, 10'h000, 16'h0000};
    treq <= 16'sd100;
    settle(10);
    cmp(tcmd, 16'sd100, "inputs ignored");
    cmp(drv.blockPos, 1'b0, "no block flag");
    sendCmd(1'b1);
    cmp(a, 1'b1, "command taken");
    doReset();
    cfg.inputSetup <= SETUP_ALARM;
    settle(10);
    cmp({rAlm, aStop}, 2'h3, "run inhibit alarm");
    doReset();
    homing <= 1'b1;
    settle(10);
    cmp(rAlm, 1'b0, "homing suspends");
    // homing without travel inputs: pins unassigned, driven low
    posPin <= 1'b0;
    settle(10);
    cmp({rAlm, aStop, sBits}, 4'h0, "homing no inputs");
    posPin <= 1'b1;
    homing <= 1'b0;
    doReset();
    cfg.inputSetup <= SETUP_DIRECTION;
    speed <= 16'sd200;
    othAlm <= 1'b1;
    settle(10);
    cmp({aStop, drv.dynamicBrake, drv.freeRun, drv.emergencyStop}, 4'h8, "alarm first");
    othAlm <= 1'b0;
  endtask

  task automatic scSeq;
    logic [1:0] sq;
    logic [PCT_W-1:0] pct;
    int nDisc;
    for (int i = 0; i < 4; i++) begin
      sq = (i > 2) ? 2'h2 : 2'(i);
      pct = (i == 3) ? 10'h000 : 10'h032;
      posPin <= 1'b0;
      doReset();
      cfg <= '{SETUP_DIRECTION, sq, pct, 16'h0000};
      speed <= 16'sd200;
      treq <= -16'sd400;
      settle(10);
      posPin <= 1'b1;
      settle(10);
      cmp({drv.dynamicBrake, drv.freeRun, drv.emergencyStop}, 3'h4 >> sq, "method");
      cmp(drv.forcePosCtrl && drv.haltPosCmd && drv.clearDeviation, 1'b1, "decel");
      if (sq == SEQ_EMERGENCY)
        cmp(tcmd, (i == 3) ? 16'(-300) : 16'(-50), "estop limit");
      speed <= 16'sd10;
      treq <= (sq == SEQ_EMERGENCY) ? -16'sd400 : 16'sd100;
      watchDiscard(nDisc);
      cmp(16'(nDisc), 16'h0001, "end of decel discard");
      cmp({drv.dynamicBrake, drv.freeRun, drv.emergencyStop}, 3'h0, "stopped");
      cmp(drv.clearDeviation, 1'b0, "deviation held");
      cmp(tcmd, (sq == SEQ_EMERGENCY) ? 16'(-300) : 16'h0000, "after stop");
    end
  endtask

  task automatic scInstStop;
    int n;
    posPin <= 1'b0;
    doReset();
    cfg <= '{SETUP_DIRECTION, SEQ_DYN_BRAKE, 10'h032, 16'h0000};
    speed <= 16'sd10;
    settle(10);
    posPin <= 1'b1;
    watchDiscard(n);
    cmp(16'(n), 16'h0001, "instant stop discard");
    cmp({drv.dynamicBrake, drv.forcePosCtrl}, 2'h0, "no deceleration");
  endtask

  initial begin
    rst = 1'b1;
    {posPin, negPin, homing, othAlm, issue, dirPos, brk} = 7'h00;
    cfg = '{SETUP_DIRECTION, SEQ_DYN_BRAKE, 10'h000, 16'h0000};
    speed = 16'sd0;
    treq = 16'sd0;
    nlim = 10'h12C;
    doReset();
    scStatus();
    scBlock();
    scIgnoreAlarm();
    scSeq();
    scInstStop();
    final_report();
  end

  initial begin
    settle(20000);
    miscompares++;
    final_report();
  end
endmodule

// ---- hw/otis_pkg.sv ----
package otis_pkg;

  localparam int TORQUE_W = 16;
  localparam int SPEED_W = 16;
  localparam int PCT_W = 10;

  // inhibit_input_setup encodings
  localparam logic [1:0] SETUP_DIRECTION = 2'h0;
  localparam logic [1:0] SETUP_DISABLED = 2'h1;
  localparam logic [1:0] SETUP_ALARM = 2'h2;

  // inhibit_stop_sequence encodings
  localparam logic [1:0] SEQ_DYN_BRAKE = 2'h0;
  localparam logic [1:0] SEQ_FREE_RUN = 2'h1;
  localparam logic [1:0] SEQ_EMERGENCY = 2'h2;

  // network_function_expansion bit positions
  localparam int EXP_HIDE_STATUS = 2;
  localparam int EXP_SWAP_STATUS = 3;
  localparam int EXP_INVERT_STATUS = 6;
  localparam int EXP_CMD_ERROR = 9;

  // stop threshold, r/min; emergency torque percent cap
  localparam logic [SPEED_W-1:0] STOP_SPEED_RPM = 16'h001E;
  localparam logic [PCT_W-1:0] ESTOP_PCT_MAX = 10'h1F4;

  typedef enum logic [1:0] {
    OTIS_IDLE = 2'b00,
    OTIS_DECEL = 2'b01,
    OTIS_STOPPED = 2'b10
  } otis_state_e;

  // sequence settings, latched once per control cycle
  typedef struct packed {
    logic [1:0] inputSetup;
    logic [1:0] stopSeq;
    logic [PCT_W-1:0] estopTorquePct;
    logic [15:0] expansion;
  } otis_cfg_s;

  // drive outputs steered by the sequencer
  typedef struct packed {
    logic dynamicBrake;
    logic freeRun;
    logic emergencyStop;
    logic forcePosCtrl;
    logic haltPosCmd;
    logic clearDeviation;
    logic discardDeviation;
    logic blockPos;
    logic blockNeg;
  } otis_drive_s;

endpackage

// ---- hw/otis_sequencer.sv ----
`timescale 1ns/1ns
// Contract
// [RL1] setup 0: positive input blocks cw, negative blocks ccw, motion stops
// [RL2] setup 0: torque toward an inhibited direction is always zero
// [RL3] setup 1: both inhibit inputs ignored entirely (code still reports them on statusBits unless expansion bit 2 is set)
// [RL4] setup 2: either input on raises the run-inhibition alarm
// [RL5] any alarm overrides the over-travel stop sequence
// [RL6] stop-sequence setting used only when setup is 0
// [RL7] decel: 0 brake, 1 free run, 2 emergency stop; deviation cleared
// [RL8] after stop: 0/1 zero torque inhibited way; 2 normal; deviation held (code zeroes that torque under all three settings)
// [RL9] emergency stop limits torque to the emergency percent setting
// [RL10] emergency setting 0 uses the normal torque limit
// [RL11] decel forces position control and halts position command
// [RL12] clearing: command follows feedback; discard deviation at stop
// [RL13] below 30 r/min deceleration ends, motor treated as stopped
// [RL14] host issues no command toward an inhibited direction
// [RL15] inhibited-direction command ignored; error if expansion bit 9 set
// [RL16] setup 1: expansion bit 2 hides status bits too
// [RL17] expansion bit 3 swaps status bit placement
// [RL18] expansion bit 6 inverts status polarity
// [RL19] during profile homing both settings are suspended
// [RL20] integrator unassigns inhibit inputs when homing without them
// [RL21] setup normally 1 when the controller manages over-travel
// [RL22] inputs sampled per control cycle; settings change between cycles
module otis_sequencer import otis_pkg::*; #(
  parameter int CYCLE_DIV = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // limit pins
  input wire logic posLimitPin,
  input wire logic negLimitPin,
  // settings
  input wire otis_cfg_s cfgIn,
  input wire logic homingActive,
  input wire logic otherAlarm,
  // motion state
  input wire logic signed [SPEED_W-1:0] motorSpeed,
  input wire logic signed [TORQUE_W-1:0] torqueRequest,
  input wire logic [PCT_W-1:0] normalLimitPct,
  // host command
  input wire logic cmdValid,
  input wire logic cmdDirPos,
  // drive outputs
  output otis_drive_s drive,
  output logic signed [TORQUE_W-1:0] torqueCmd,
  output logic runInhibitAlarm,
  output logic alarmStop,
  output logic cmdAccept,
  output logic cmdError,
  output logic [1:0] statusBits,
  output logic statusValid
);

  localparam int DIV_W = $clog2(CYCLE_DIV + 1);

  logic [DIV_W-1:0] divCnt_reg;
  logic [DIV_W-1:0] divCnt_next;
  logic cycleTick;
  logic [1:0] limSync;
  logic posLim_reg;
  logic negLim_reg;
  otis_cfg_s cfg_reg;
  otis_state_e state_reg;
  otis_state_e state_next;
  logic stopPos_reg;
  logic stopNeg_reg;
  otis_drive_s drive_reg;
  otis_drive_s drive_next;
  logic signed [TORQUE_W-1:0] torque_reg;
  logic signed [TORQUE_W-1:0] clampOut;
  logic inhAlarm_reg;
  logic alarmStop_reg;
  logic cmdAccept_reg;
  logic cmdError_reg;
  logic [1:0] status_reg;
  logic statusValid_reg;

  otis_sync #(.WIDTH(2)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn({posLimitPin, negLimitPin}),
    .syncOut(limSync)
  );

  // control-cycle enable
  assign cycleTick = (divCnt_reg == DIV_W'(CYCLE_DIV - 1));
  assign divCnt_next = cycleTick ? '0 : divCnt_reg + 1'b1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_next;
    end
  end

  // [RL22] sample inputs and settings per cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      posLim_reg <= 1'b0;
      negLim_reg <= 1'b0;
      cfg_reg <= '{inputSetup: SETUP_DISABLED, default: '0};
    end else if (cycleTick) begin
      posLim_reg <= limSync[1];
      negLim_reg <= limSync[0];
      cfg_reg <= cfgIn;
    end
  end

  wire logic setupDir;
  wire logic setupAlarm;
  wire logic anyLimit;
  wire logic alarmNow;
  wire logic seqOff;
  wire logic movingPos;
  wire logic movingNeg;
  wire logic trigPos;
  wire logic trigNeg;
  wire logic anyTrig;
  wire logic instStop;
  wire logic belowStop;
  wire logic [SPEED_W-1:0] speedAbs;
  wire logic inhPos;
  wire logic inhNeg;
  wire logic cmdBlocked;
  wire logic hideStatus;
  wire logic [1:0] placed;
  wire logic [1:0] dirLim;
  wire logic [1:0] dirMoving;
  wire logic [1:0] dirTrig;
  wire logic [1:0] dirInh;
  wire logic seqBrake;
  wire logic seqFree;
  wire logic seqEstop;

  // [RL19] homing suspends both settings
  // [RL3] setup 1 disables the inputs
  assign setupDir = (cfg_reg.inputSetup == SETUP_DIRECTION) && !homingActive;
  assign setupAlarm = (cfg_reg.inputSetup == SETUP_ALARM) && !homingActive;
  assign anyLimit = posLim_reg || negLim_reg;
  // [RL4] run-inhibition alarm
  assign alarmNow = otherAlarm || (setupAlarm && anyLimit);
  // [RL5] [RL6] alarm or another setup takes the sequence off the drive
  assign seqOff = alarmNow || !setupDir;
  assign speedAbs = motorSpeed[SPEED_W-1] ? SPEED_W'(-motorSpeed) : motorSpeed;
  // [RL13] stop threshold
  assign belowStop = speedAbs < STOP_SPEED_RPM;
  // a crawl below the threshold still counts as motion into the limit
  assign movingPos = !motorSpeed[SPEED_W-1] && (motorSpeed != '0);
  assign movingNeg = motorSpeed[SPEED_W-1];
  // index 1 is the positive direction, index 0 the negative one
  assign dirLim = {posLim_reg, negLim_reg};
  assign dirMoving = {movingPos, movingNeg};
  for (genvar d = 0; d < 2; d++) begin : g_dir
    // [RL1] motion into an active limit
    assign dirTrig[d] = setupDir && dirLim[d] && dirMoving[d];
    // [RL2] blocking holds whatever the state
    assign dirInh[d] = setupDir && dirLim[d];
  end
  assign trigPos = dirTrig[1];
  assign trigNeg = dirTrig[0];
  assign inhPos = dirInh[1];
  assign inhNeg = dirInh[0];
  assign anyTrig = trigPos || trigNeg;
  // [RL12] limit met below the threshold is an instantaneous stop
  assign instStop = anyTrig && belowStop;
  // [RL7] stopping method decode
  assign seqBrake = (cfg_reg.stopSeq == SEQ_DYN_BRAKE);
  assign seqFree = (cfg_reg.stopSeq == SEQ_FREE_RUN);
  assign seqEstop = (cfg_reg.stopSeq == SEQ_EMERGENCY);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OTIS_IDLE: begin
        if (anyTrig) begin
          state_next = belowStop ? OTIS_STOPPED : OTIS_DECEL;
        end
      end
      OTIS_DECEL: begin
        // [RL13] end deceleration
        if (belowStop) begin
          state_next = OTIS_STOPPED;
        end
      end
      OTIS_STOPPED: begin
        if (!(inhPos && stopPos_reg) && !(inhNeg && stopNeg_reg)) begin
          state_next = OTIS_IDLE;
        end
      end
      default: state_next = OTIS_IDLE;
    endcase
    // [RL5] alarm sequence overrides
    // [RL6] sequence only used with setup 0
    if (seqOff) begin
      state_next = OTIS_IDLE;
    end
  end

  always_comb begin
    drive_next = '0;
    drive_next.blockPos = inhPos;
    drive_next.blockNeg = inhNeg;
    case (state_reg)
      OTIS_DECEL: begin
        // [RL7] stopping method per setting
        drive_next.dynamicBrake = seqBrake;
        drive_next.freeRun = seqFree;
        drive_next.emergencyStop = seqEstop;
        // [RL11] forced position control
        drive_next.forcePosCtrl = 1'b1;
        drive_next.haltPosCmd = 1'b1;
        // [RL12] command follows feedback
        drive_next.clearDeviation = 1'b1;
        drive_next.discardDeviation = belowStop;
      end
      OTIS_STOPPED: begin
        // [RL8] deviation held after stop, also when the limit releases
        drive_next.discardDeviation = 1'b0;
      end
      default: begin
        // [RL12] instantaneous stop discards deviation
        drive_next.discardDeviation = instStop;
      end
    endcase
    if (seqOff) begin
      drive_next.dynamicBrake = 1'b0;
      drive_next.freeRun = 1'b0;
      drive_next.emergencyStop = 1'b0;
      drive_next.forcePosCtrl = 1'b0;
      drive_next.haltPosCmd = 1'b0;
      drive_next.clearDeviation = 1'b0;
      drive_next.discardDeviation = 1'b0;
    end
  end

  wire logic [PCT_W-1:0] estopPct;
  assign estopPct = (cfg_reg.estopTorquePct > ESTOP_PCT_MAX) ?
                    ESTOP_PCT_MAX : cfg_reg.estopTorquePct;

  // next-state flags feed the clamp so torque and drive flags move on one edge
  otis_torque_clamp u_clamp (
    .torqueIn(torqueRequest),
    .normalLimitPct(normalLimitPct),
    .estopLimitPct(estopPct),
    .estopActive(drive_next.emergencyStop),
    .blockPos(drive_next.blockPos),
    .blockNeg(drive_next.blockNeg),
    .torqueOut(clampOut)
  );

  // [RL15] inhibited-direction command
  assign cmdBlocked = cmdDirPos ? inhPos : inhNeg;
  // [RL16] hide status when disabled
  assign hideStatus = (cfg_reg.inputSetup == SETUP_DISABLED) &&
                      cfg_reg.expansion[EXP_HIDE_STATUS];
  // [RL17] status bit placement
  assign placed = cfg_reg.expansion[EXP_SWAP_STATUS] ? {negLim_reg, posLim_reg} :
                  {posLim_reg, negLim_reg};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= OTIS_IDLE;
      stopPos_reg <= 1'b0;
      stopNeg_reg <= 1'b0;
      drive_reg <= '0;
      torque_reg <= '0;
      inhAlarm_reg <= 1'b0;
      alarmStop_reg <= 1'b0;
      cmdAccept_reg <= 1'b0;
      cmdError_reg <= 1'b0;
      status_reg <= 2'h0;
      statusValid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == OTIS_IDLE && state_next != OTIS_IDLE) begin
        stopPos_reg <= trigPos;
        stopNeg_reg <= trigNeg;
      end
      drive_reg <= drive_next;
      torque_reg <= clampOut;
      inhAlarm_reg <= setupAlarm && anyLimit;
      alarmStop_reg <= alarmNow;
      cmdAccept_reg <= cmdValid && !cmdBlocked;
      cmdError_reg <= cmdValid && cmdBlocked && cfg_reg.expansion[EXP_CMD_ERROR];
      // [RL18] status polarity
      status_reg <= hideStatus ? 2'h0 :
                    (cfg_reg.expansion[EXP_INVERT_STATUS] ? ~placed : placed);
      statusValid_reg <= !hideStatus;
    end
  end

  assign drive = drive_reg;
  assign torqueCmd = torque_reg;
  assign runInhibitAlarm = inhAlarm_reg;
  assign alarmStop = alarmStop_reg;
  assign cmdAccept = cmdAccept_reg;
  assign cmdError = cmdError_reg;
  assign statusBits = status_reg;
  assign statusValid = statusValid_reg;

endmodule

// ---- hw/otis_sync.sv ----
`timescale 1ns/1ns
// two-flop synchroniser for the limit pins
module otis_sync import otis_pkg::*; #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

// ---- hw/otis_torque_clamp.sv ----
`timescale 1ns/1ns
// combinational torque limiter: direction blocks and emergency limit
module otis_torque_clamp import otis_pkg::*; (
  // request
  input wire logic signed [TORQUE_W-1:0] torqueIn,
  input wire logic [PCT_W-1:0] normalLimitPct,
  input wire logic [PCT_W-1:0] estopLimitPct,
  input wire logic estopActive,
  input wire logic blockPos,
  input wire logic blockNeg,
  // result
  output logic signed [TORQUE_W-1:0] torqueOut
);

  wire logic [PCT_W-1:0] estopEff;
  wire logic [PCT_W-1:0] limitPct;
  wire logic signed [TORQUE_W-1:0] limitPos;
  wire logic signed [TORQUE_W-1:0] limitNeg;
  wire logic signed [TORQUE_W-1:0] clipped;

  // [RL10] zero setting falls back
  assign estopEff = (estopLimitPct == '0) ? normalLimitPct : estopLimitPct;
  // [RL9] emergency torque limit
  assign limitPct = estopActive ? estopEff : normalLimitPct;
  assign limitPos = $signed({{(TORQUE_W-PCT_W){1'b0}}, limitPct});
  assign limitNeg = -limitPos;
  assign clipped = (torqueIn > limitPos) ? limitPos :
                   (torqueIn < limitNeg) ? limitNeg : torqueIn;
  // [RL2] zero inhibited direction
  assign torqueOut = ((blockPos && clipped > 0) || (blockNeg && clipped < 0)) ?
                     '0 : clipped;

endmodule
